// ---- rtl/adcc_pkg.sv ----
// Shared constants, types and helpers for the converter control block
package adcc_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_CLK_DIV    = 8'hF2;
   localparam logic [7:0] ADDR_CONTROL    = 8'hF3;
   localparam logic [7:0] ADDR_RES_LOW    = 8'hF4;
   localparam logic [7:0] ADDR_RES_HIGH   = 8'hF5;
   localparam logic [7:0] ADDR_PIN_ASSIGN = 8'hF6;

   // Control register field positions
   localparam int CTRL_CHAN_LSB   = 0;
   localparam int CTRL_CHAN_MSB   = 2;
   localparam int CTRL_START_BIT  = 3;
   localparam int CTRL_DONE_BIT   = 4;
   localparam int CTRL_ENABLE_BIT = 5;
   localparam int CTRL_QUIET_BIT  = 6;

   // Divider field and result layout
   localparam int DIV_FIELD_MSB = 4;
   localparam int RES_UPPER_LSB = 2;

   // Values after reset
   localparam logic [4:0] RST_CLK_DIV    = 5'h00;
   localparam logic [7:0] RST_PIN_ASSIGN = 8'h00;
   localparam logic [7:0] RST_RES_UPPER  = 8'h00;
   localparam logic [1:0] RST_RES_LOWER  = 2'h0;
   localparam logic [2:0] RST_CHAN       = 3'h0;

   // Division factor for a zero field (64)
   localparam logic [7:0] DIV_ZERO_FACTOR = 8'h40;
   localparam logic [2:0] DIV_STEP_DFLT   = 3'h2;

   // Conversion length in converter clock periods
   localparam logic [3:0] CONV_PERIODS = 4'hB;
   localparam logic [3:0] LAST_PERIOD  = CONV_PERIODS - 4'h1;

   // Converter clock ceiling and software settle time after enable
   localparam int MAX_CONV_CLK_KHZ = 700;
   localparam int CLK_PERIOD_NS    = 4;
   localparam int SETUP_TIME_NS    = 4000;
   localparam int SETUP_CYCLES     =
      (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [9:0] RES_FULL_SCALE = 10'h3FF;
   localparam logic [9:0] RES_ZERO       = 10'h000;

   typedef enum logic [1:0] {
      ADCC_IDLE    = 2'b00,
      ADCC_SAMPLE  = 2'b01,
      ADCC_CONVERT = 2'b10
   } adcc_state_t;

   // Oscillator cycles per converter clock period
   function automatic logic [7:0] div_factor(input logic [4:0] field,
                                             input logic [2:0] step);
      logic [7:0] prod;
      prod = {3'h0, field} * {5'h00, step};
      div_factor = (field == 5'h00) ? DIV_ZERO_FACTOR : prod;
   endfunction : div_factor

endpackage : adcc_pkg

// ---- rtl/adcc_tick_if.sv ----
// Carrier between the control logic and the converter clock divider
`timescale 1ns/1ns
interface adcc_tick_if;
   logic [4:0] divField;
   logic       restart;
   logic       run;
   logic       tick;

   modport ctrl (output divField, output restart, output run, input tick);
   modport div  (input divField, input restart, input run, output tick);
endinterface : adcc_tick_if

// ---- rtl/adcc_clk_div.sv ----
// Converter clock prescaler producing one tick per converter period
`timescale 1ns/1ns
module adcc_clk_div #(
   parameter logic [2:0] DIV_STEP = adcc_pkg::DIV_STEP_DFLT
) (
   input wire logic clk,          // oscillator clock
   input wire logic nrst,         // async reset, active low
   adcc_tick_if.div tk            // divider controls and tick
);

   logic [7:0] cnt_q;
   logic [7:0] factor;

   // Nonzero fields grow the period linearly with the field
   assign factor = adcc_pkg::div_factor(tk.divField, DIV_STEP); // see R18

   // Restart aligns the first period to the conversion start
   always_ff @(posedge clk or negedge nrst) begin // see R7
      if (!nrst) begin
         cnt_q   <= 8'h00;
         tk.tick <= 1'b0;
      end else if (tk.restart || !tk.run) begin
         cnt_q   <= 8'h00;
         tk.tick <= 1'b0;
      end else if (cnt_q == factor - 8'h01) begin // see R8
         cnt_q   <= 8'h00;
         tk.tick <= 1'b1;
      end else begin
         cnt_q   <= cnt_q + 8'h01;
         tk.tick <= 1'b0;
      end
   end

endmodule : adcc_clk_div

// ---- rtl/adcc_top.sv ----
// Converter control, register file and result capture
//
// Summary of operation
// R1: Writing start bit begins one conversion
// R2: Start bit reads busy, clears at end
// R3: Done flag set with results, software clears
// R4: Interrupt when done flag and enable set
// R5: Channel field selects input zero to seven
// R6: Full scale 3FFh, ground 000h, clamped
// R7: Converter clock comes from prescaled oscillator
// R8: Five-bit divide field, zero divides by 64
// R9: Enable bit powers converter, clear is standby
// R10: Quiet bit halts CPU during conversion
// R11: High result register holds bits nine to two
// R12: Low result register holds bits one, zero
// R13: Pin assignment bits mark pins analog
// R14: Start on unassigned pin does nothing
// R15: Software waits 4 us after enabling
// R16: Conversion lasts eleven converter clock periods
// R17: Quiet conversion defers other interrupts
// R18: Nonzero field grows the division factor
// R19: Start during conversion is ignored
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module adcc_top #(
   parameter logic [2:0] DIV_STEP = adcc_pkg::DIV_STEP_DFLT
) (
   input  wire logic       clk,             // oscillator clock, 250 MHz
   input  wire logic       nrst,            // async reset, active low
   input  wire logic [7:0] regAddr,         // register address
   input  wire logic [7:0] regWdata,        // register write data
   input  wire logic       regWr,           // write strobe
   input  wire logic       regRd,           // read strobe
   output logic      [7:0] regRdata,        // read data, cycle after read
   input  wire logic       convIrqEnable,   // converter interrupt enable
   output logic            convIrq,         // end of conversion request
   output logic            cpuHalt,         // halt CPU, defer other irqs
   output logic      [7:0] pinAnalogSelect, // pins given to analog use
   output logic      [2:0] coreChannel,     // mux channel to the core
   output logic            corePowerOn,     // core powered, else standby
   output logic            coreSample,      // sample and hold period
   output logic            coreConvert,     // bit conversion periods
   input  wire logic [9:0] coreResult,      // raw code from the core
   input  wire logic       coreAboveRef,    // input above reference
   input  wire logic       coreBelowGnd     // input below ground
);

   adcc_tick_if tk ();

   adcc_clk_div #(
      .DIV_STEP (DIV_STEP)
   ) u_div (
      .clk  (clk),
      .nrst (nrst),
      .tk   (tk)
   );

   adcc_pkg::adcc_state_t state_q;
   adcc_pkg::adcc_state_t state_d;
   logic [3:0] periodCnt_q;
   logic [3:0] periodCnt_d;
   logic [4:0] clkDiv_q;
   logic [7:0] pinAssign_q;
   logic [2:0] chanSel_q;
   logic       enable_q;
   logic       quiet_q;
   logic       done_q;
   logic       done_d;
   logic       quietConv_q;
   logic       quietConv_d;
   logic [7:0] resUpper_q;
   logic [1:0] resLower_q;
   logic [7:0] regRdata_q;
   logic       convIrq_q;
   logic       cpuHalt_q;
   logic [2:0] coreChannel_q;
   logic       corePowerOn_q;
   logic       coreSample_q;
   logic       coreConvert_q;
   logic       wrCtrl;
   logic       startReq;
   logic       startOk;
   logic       busy;
   logic       finish;
   logic [2:0] wrChan;
   logic [9:0] resNext;
   logic [7:0] ctrlRead;
   logic [3:0] tickSeen_q;

   assign wrCtrl   = regWr && (regAddr == adcc_pkg::ADDR_CONTROL);
   assign wrChan   = regWdata[adcc_pkg::CTRL_CHAN_MSB:adcc_pkg::CTRL_CHAN_LSB];
   assign busy     = (state_q != adcc_pkg::ADCC_IDLE);
   // Start needs enable in the written value and an analog pin
   assign startReq = wrCtrl && regWdata[adcc_pkg::CTRL_START_BIT]
                     && !busy; // see R19
   assign startOk  = startReq && regWdata[adcc_pkg::CTRL_ENABLE_BIT] // see R9
                     && pinAssign_q[wrChan]; // see R14
   assign finish   = (state_q == adcc_pkg::ADCC_CONVERT) && tk.tick
                     && (periodCnt_q == adcc_pkg::LAST_PERIOD) && enable_q;

   assign tk.divField = clkDiv_q;
   assign tk.restart  = startOk;
   assign tk.run      = busy;

   // Sequencer: one sample period then ten bit periods
   always_comb begin
      state_d     = state_q;
      periodCnt_d = periodCnt_q;
      if (busy && !enable_q) begin
         // Standby drops a conversion in flight, no result
         state_d     = adcc_pkg::ADCC_IDLE; // see R9
         periodCnt_d = 4'h0;
      end else begin
         unique case (state_q)
            adcc_pkg::ADCC_IDLE: begin
               if (startOk) begin // see R1
                  state_d     = adcc_pkg::ADCC_SAMPLE;
                  periodCnt_d = 4'h0;
               end
            end
            adcc_pkg::ADCC_SAMPLE: begin
               if (tk.tick) begin // see R16
                  state_d     = adcc_pkg::ADCC_CONVERT;
                  periodCnt_d = 4'h1;
               end
            end
            adcc_pkg::ADCC_CONVERT: begin
               if (finish) begin // see R2
                  state_d     = adcc_pkg::ADCC_IDLE;
                  periodCnt_d = 4'h0;
               end else if (tk.tick) begin // see R16
                  periodCnt_d = periodCnt_q + 4'h1;
               end
            end
            default: begin
               state_d     = adcc_pkg::ADCC_IDLE;
               periodCnt_d = 4'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q     <= adcc_pkg::ADCC_IDLE;
         periodCnt_q <= 4'h0;
      end else begin
         state_q     <= state_d;
         periodCnt_q <= periodCnt_d;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clkDiv_q    <= adcc_pkg::RST_CLK_DIV;
         pinAssign_q <= adcc_pkg::RST_PIN_ASSIGN;
         chanSel_q   <= adcc_pkg::RST_CHAN;
         enable_q    <= 1'b0;
         quiet_q     <= 1'b0;
      end else begin
         if (regWr && (regAddr == adcc_pkg::ADDR_CLK_DIV)) begin // see R8
            clkDiv_q <= regWdata[adcc_pkg::DIV_FIELD_MSB:0];
         end
         if (regWr && (regAddr == adcc_pkg::ADDR_PIN_ASSIGN)) begin
            pinAssign_q <= regWdata; // see R13
         end
         if (wrCtrl) begin
            chanSel_q <= wrChan; // see R5
            enable_q  <= regWdata[adcc_pkg::CTRL_ENABLE_BIT];
            quiet_q   <= regWdata[adcc_pkg::CTRL_QUIET_BIT];
         end
      end
   end

   // Hardware set beats a software clear in the same cycle
   always_comb begin
      done_d = done_q;
      if (wrCtrl && !regWdata[adcc_pkg::CTRL_DONE_BIT]) begin
         done_d = 1'b0;
      end
      if (finish) begin
         done_d = 1'b1; // see R3
      end
   end

   // Mode is fixed at start; later writes to the bit wait
   assign quietConv_d = startOk ? regWdata[adcc_pkg::CTRL_QUIET_BIT]
                                : quietConv_q;

   // Range flags from the core override the raw code
   assign resNext = coreAboveRef ? adcc_pkg::RES_FULL_SCALE : // see R6
                    coreBelowGnd ? adcc_pkg::RES_ZERO : coreResult;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done_q      <= 1'b0;
         quietConv_q <= 1'b0;
         resUpper_q  <= adcc_pkg::RST_RES_UPPER;
         resLower_q  <= adcc_pkg::RST_RES_LOWER;
      end else begin
         done_q      <= done_d;
         quietConv_q <= quietConv_d;
         if (finish) begin
            resUpper_q <= resNext[9:adcc_pkg::RES_UPPER_LSB]; // see R11
            resLower_q <= resNext[adcc_pkg::RES_UPPER_LSB-1:0]; // see R12
         end
      end
   end

   // Registered outputs towards the core and the CPU
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         convIrq_q     <= 1'b0;
         cpuHalt_q     <= 1'b0;
         coreChannel_q <= adcc_pkg::RST_CHAN;
         corePowerOn_q <= 1'b0;
         coreSample_q  <= 1'b0;
         coreConvert_q <= 1'b0;
      end else begin
         convIrq_q     <= done_d && convIrqEnable; // see R4
         // Other interrupts stay pending until the halt drops
         cpuHalt_q     <= (state_d != adcc_pkg::ADCC_IDLE)
                          && quietConv_d; // see R10, see R17
         corePowerOn_q <= wrCtrl ? regWdata[adcc_pkg::CTRL_ENABLE_BIT]
                                 : enable_q;
         coreSample_q  <= (state_d == adcc_pkg::ADCC_SAMPLE);
         coreConvert_q <= (state_d == adcc_pkg::ADCC_CONVERT);
         if (startOk) begin
            coreChannel_q <= wrChan; // see R5
         end
      end
   end

   // Reserved bits read as zero
   assign ctrlRead = {1'b0, quiet_q, enable_q, done_q, busy, chanSel_q};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         regRdata_q <= 8'h00;
      end else if (regRd) begin
         unique case (regAddr)
            adcc_pkg::ADDR_CLK_DIV:    regRdata_q <= {3'h0, clkDiv_q};
            adcc_pkg::ADDR_CONTROL:    regRdata_q <= ctrlRead; // see R2
            adcc_pkg::ADDR_RES_LOW:    regRdata_q <= {6'h00, resLower_q};
            adcc_pkg::ADDR_RES_HIGH:   regRdata_q <= resUpper_q;
            adcc_pkg::ADDR_PIN_ASSIGN: regRdata_q <= pinAssign_q;
            default:                   regRdata_q <= 8'h00;
         endcase
      end else begin
         regRdata_q <= 8'h00;
      end
   end

   assign regRdata        = regRdata_q;
   assign convIrq         = convIrq_q;
   assign cpuHalt         = cpuHalt_q;
   assign pinAnalogSelect = pinAssign_q;
   assign coreChannel     = coreChannel_q;
   assign corePowerOn     = corePowerOn_q;
   assign coreSample      = coreSample_q;
   assign coreConvert     = coreConvert_q;

   // Helper: ticks seen since the start of a conversion
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tickSeen_q <= 4'h0;
      end else if (startOk) begin
         tickSeen_q <= 4'h0;
      end else if (busy && tk.tick) begin
         tickSeen_q <= tickSeen_q + 4'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_start_begins: assert property ( // see R1
      startOk |=> (state_q == adcc_pkg::ADCC_SAMPLE) && coreSample_q)
      else $error("accepted start did not begin sampling");

   chk_busy_readback: assert property ( // see R2
      regRd && (regAddr == adcc_pkg::ADDR_CONTROL)
      |=> regRdata_q[adcc_pkg::CTRL_START_BIT] == $past(busy))
      else $error("start bit readback differs from busy");

   chk_done_with_data: assert property ( // see R3
      finish |=> done_q && !busy
                 && ({resUpper_q, resLower_q} == $past(resNext)))
      else $error("done flag or result missing after conversion");

   chk_irq_source: assert property ( // see R4
      $rose(convIrq_q) |-> done_q && $past(convIrqEnable))
      else $error("interrupt without done flag and enable");

   chk_channel_latch: assert property ( // see R5
      startOk |=> coreChannel_q == $past(wrChan))
      else $error("core channel not taken from start write");

   chk_clamp_high: assert property ( // see R6
      finish && coreAboveRef |=> {resUpper_q, resLower_q} == 10'h3FF)
      else $error("over range input not clamped to full scale");

   chk_zero_div: assert property ( // see R8
      startOk && (clkDiv_q == 5'h00)
      |=> !tk.tick [*8] ##57 (tk.tick || !busy))
      else $error("zero divide field period is not 64");

   chk_standby_stop: assert property ( // see R9
      busy && !enable_q |=> !busy && !coreSample_q && !coreConvert_q)
      else $error("standby did not stop conversion");

   chk_quiet_halt: assert property ( // see R10
      startOk && regWdata[adcc_pkg::CTRL_QUIET_BIT] |=> cpuHalt_q
      ##0 (cpuHalt_q throughout (busy [*1])))
      else $error("quiet conversion did not halt the cpu");

   chk_halt_ends: assert property ( // see R17
      $fell(busy) |-> !cpuHalt_q)
      else $error("cpu halt held past end of conversion");

   chk_pin_mirror: assert property ( // see R13
      regWr && (regAddr == adcc_pkg::ADDR_PIN_ASSIGN)
      |=> pinAnalogSelect == $past(regWdata))
      else $error("pin assignment not mirrored to pins");

   chk_unassigned: assert property ( // see R14
      startReq && !pinAssign_q[wrChan] |=> !busy && !coreSample_q)
      else $error("start on digital pin began a conversion");

   chk_eleven_periods: assert property ( // see R16
      finish |-> tickSeen_q == 4'hA)
      else $error("conversion did not take eleven periods");

   chk_no_restart: assert property ( // see R19
      busy && !finish && wrCtrl && regWdata[adcc_pkg::CTRL_START_BIT]
      && regWdata[adcc_pkg::CTRL_ENABLE_BIT] && enable_q
      |=> busy && (coreChannel_q == $past(coreChannel_q)))
      else $error("start during conversion restarted it");

   chk_low_result: assert property ( // see R12
      finish && !coreAboveRef && !coreBelowGnd
      |=> resLower_q == $past(coreResult[1:0]))
      else $error("low result bits wrong");

endmodule : adcc_top

// ---- test/adcc_core_model.sv ----
// Behavioural analog converter core with eight multiplexed inputs
`timescale 1ns/1ns
module adcc_core_model (
   input  wire logic        clk,          // oscillator clock
   input  wire logic [2:0]  coreChannel,  // selected input
   input  wire logic        corePowerOn,  // core powered
   input  wire logic        coreSample,   // sample and hold period
   input  wire logic        coreConvert,  // bit conversion periods
   input  wire logic [79:0] chanCode,     // ten-bit code per input
   input  wire logic [15:0] chanRange,    // 01 above ref, 10 below gnd
   output logic      [9:0]  coreResult,   // code to the control logic
   output logic             coreAboveRef, // input above reference
   output logic             coreBelowGnd  // input below ground
);
   logic [9:0] junkQ = 10'h2A5;
   logic       convQ = 1'b0;
   logic       live;
   logic [1:0] rng;

   // Held one cycle past the convert window so the finish edge sees it
   assign live = corePowerOn && (coreConvert || convQ);
   assign rng  = chanRange[coreChannel*2 +: 2];

   always @(posedge clk) begin
      convQ <= coreConvert;
      junkQ <= ~junkQ + 10'h001;
   end

   // Outside a conversion the lines wander instead of holding a value
   assign coreResult   = live ? chanCode[coreChannel*10 +: 10] : junkQ;
   assign coreAboveRef = live ? rng[0] : junkQ[0];
   assign coreBelowGnd = live ? rng[1] : junkQ[1];
endmodule : adcc_core_model

// ---- test/adcc_top_tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module adcc_top_tb;
   localparam logic [2:0] STEP  = 3'h2;
   localparam int         LIMIT = 30000;
   logic        clk, nrst, regWr, regRd, convIrqEnable;
   logic [7:0]  regAddr, regWdata, regRdata, pinAnalogSelect, v;
   logic        convIrq, cpuHalt, corePowerOn, coreSample, coreConvert;
   logic        coreAboveRef, coreBelowGnd, busy, wasBusy;
   logic [2:0]  coreChannel;
   logic [9:0]  coreResult, e;
   logic [79:0] chanCode;
   logic [15:0] chanRange;
   logic [9:0]  codeTab [8];
   int          nFail, samplesChecked, cyc, busyLen, n, f;

   adcc_top #(.DIV_STEP(STEP)) uut (.clk(clk), .nrst(nrst),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .convIrqEnable(convIrqEnable), .convIrq(convIrq),
      .cpuHalt(cpuHalt), .pinAnalogSelect(pinAnalogSelect),
      .coreChannel(coreChannel), .corePowerOn(corePowerOn),
      .coreSample(coreSample), .coreConvert(coreConvert),
      .coreResult(coreResult), .coreAboveRef(coreAboveRef),
      .coreBelowGnd(coreBelowGnd));

   adcc_core_model core (.clk(clk), .coreChannel(coreChannel),
      .corePowerOn(corePowerOn), .coreSample(coreSample),
      .coreConvert(coreConvert), .chanCode(chanCode),
      .chanRange(chanRange), .coreResult(coreResult),
      .coreAboveRef(coreAboveRef), .coreBelowGnd(coreBelowGnd));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Length of the last busy window, sample plus convert periods
   assign busy = coreSample || coreConvert;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      wasBusy <= busy;
      if (busy && !wasBusy) busyLen <= 1;
      else if (busy) busyLen <= busyLen + 1;
      if (cyc == LIMIT) begin
         nFail++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         nFail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk({2'h0, d}, {2'h0, exp});
   endtask : rdchk

   // Poll the done flag; a slow divider needs several hundred polls
   task automatic wait_done();
      logic [7:0] d;
      int k;
      d = 8'h00;
      for (k = 0; k < 600 && !d[4]; k++) rd(8'hF3, d);
   endtask : wait_done

   initial begin
      {nrst, regWr, regRd, convIrqEnable, regAddr, regWdata} = '0;
      {nFail, samplesChecked, cyc, busyLen, wasBusy} = '0;
      codeTab = '{10'h001, 10'h2AA, 10'h155, 10'h3FE,
                  10'h0F0, 10'h30C, 10'h123, 10'h2E7};
      for (n = 0; n < 8; n++) chanCode[n*10 +: 10] = codeTab[n];
      chanRange = 16'h9000;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      rdchk(8'hF2, 8'h00);
      rdchk(8'hF3, 8'h00);
      rdchk(8'hF4, 8'h00);
      rdchk(8'hF5, 8'h00);
      rdchk(8'hF6, 8'h00);
      rdchk(8'hF7, 8'h00);
      $display("test reset done");
      wr(8'hF7, 8'hFF);
      wr(8'hF4, 8'hFF);
      wr(8'hF5, 8'hFF);
      rdchk(8'hF4, 8'h00);
      rdchk(8'hF5, 8'h00);
      wr(8'hF6, 8'hA5);
      rdchk(8'hF6, 8'hA5);
      chk({2'h0, pinAnalogSelect}, 10'h0A5);
      wr(8'hF2, 8'hFF);
      rdchk(8'hF2, 8'h1F);
      wr(8'hF3, 8'h80);
      rdchk(8'hF3, 8'h00);
      $display("test registers done");
      wr(8'hF6, 8'hFF);
      wr(8'hF2, 8'h01);
      wr(8'hF3, 8'h20);
      #1 chk({9'h0, corePowerOn}, 10'h001);
      repeat (adcc_pkg::SETUP_CYCLES) @(posedge clk);
      for (n = 0; n < 8; n++) begin
         wr(8'hF3, 8'h28 | 8'(n));
         convIrqEnable <= n[0];
         #1 chk({7'h0, coreChannel}, 10'(n));
         rdchk(8'hF3, 8'h28 | 8'(n));
         chk({9'h0, cpuHalt}, 10'h000);
         wait_done();
         e = (n == 6) ? 10'h3FF : (n == 7) ? 10'h000 : codeTab[n];
         rdchk(8'hF3, 8'h30 | 8'(n));
         rdchk(8'hF5, e[9:2]);
         rdchk(8'hF4, {6'h00, e[1:0]});
         chk({9'h0, convIrq}, {9'h0, n[0]});
         repeat (20) @(posedge clk);
         rdchk(8'hF3, 8'h30 | 8'(n));
         wr(8'hF3, 8'h20 | 8'(n));
         rdchk(8'hF3, 8'h20 | 8'(n));
         chk({9'h0, convIrq}, 10'h000);
      end
      $display("test channels done");
      wr(8'hF6, 8'hFE);
      wr(8'hF3, 8'h28);
      #1 chk({9'h0, coreSample}, 10'h000);
      rdchk(8'hF3, 8'h20);
      wr(8'hF6, 8'hFF);
      wr(8'hF3, 8'h09);
      #1 chk({9'h0, corePowerOn}, 10'h000);
      rdchk(8'hF3, 8'h01);
      $display("test refused starts done");
      wr(8'hF3, 8'h20);
      repeat (adcc_pkg::SETUP_CYCLES) @(posedge clk);
      wr(8'hF3, 8'h6A);
      repeat (2) @(posedge clk);
      #1 chk({9'h0, cpuHalt}, 10'h001);
      wait_done();
      chk({9'h0, cpuHalt}, 10'h000);
      wr(8'hF3, 8'h20);
      $display("test quiet mode done");
      for (f = 0; f < 4; f++) begin
         n = (f == 0) ? 64 : f * int'(STEP);
         wr(8'hF2, 8'(f));
         wr(8'hF3, 8'h2A);
         wr(8'hF3, 8'h2D);
         #1 chk({7'h0, coreChannel}, 10'h002);
         wait_done();
         rdchk(8'hF5, codeTab[2][9:2]);
         chk({9'h0, busyLen >= 10 * n && busyLen <= 12 * n + 2},
             10'h001);
         wr(8'hF3, 8'h20);
      end
      $display("test timing done");
      // Dropping enable mid-conversion must leave no result behind
      wr(8'hF3, 8'h2A);
      wr(8'hF3, 8'h02);
      rdchk(8'hF3, 8'h02);
      chk({8'h0, coreSample, coreConvert}, 10'h000);
      repeat (100) @(posedge clk);
      rdchk(8'hF3, 8'h02);
      $display("test standby abort done");
      give_verdict();
   end
endmodule : adcc_top_tb
